// ===== shared/pin_cfg_pkg.sv
// constants and carrier types for the pin and overtemperature configuration block
package pin_cfg_pkg;
	localparam logic [7:0] OFS_PIN_CFG = 8'h7D;
	localparam logic [7:0] OFS_TEST_ONE = 8'h7E;
	localparam logic [7:0] OFS_TEST_TWO = 8'h7F;
	localparam logic [7:0] OFS_CTRL = 8'h40;
	localparam logic [7:0] RST_PIN_CFG = 8'h00;
	localparam logic [7:0] RST_TEST = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam int ROLE_LSB = 0;
	localparam int OT_OFF_BIT = 2;
	localparam int CEIL_BIT = 3;
	localparam int BYP_LSB = 4;
	localparam int CTRL_SIGNED_BIT = 0;
	localparam int CTRL_LOCK_BIT = 1;
	localparam logic [7:0] FULL_SPEED = 8'hFF;
	localparam logic [7:0] LIMIT_OFF_OFS64 = 8'h00;
	localparam logic [7:0] LIMIT_OFF_TWOS = 8'h80;
	localparam logic [7:0] SCALE_BYPASS = 8'hFF;

	typedef enum logic [1:0] {
		ROLE_FAN_TACH = 2'b00,
		ROLE_OVERTEMP = 2'b01,
		ROLE_ALERT = 2'b10,
		ROLE_GPIO = 2'b11
	} pin_role_e;

	typedef struct packed {
		logic [3:0] bypass;
		logic ceiling_sel;
		logic ot_off;
		pin_role_e role;
	} pin_cfg_s;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
endpackage : pin_cfg_pkg

// ===== verilog/pin_cfg_regs.sv
// pin role, overtemperature and attenuator bypass configuration registers
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// RULE_01: two-bit field selects shared pin role
// RULE_02: disable bit suppresses overtemperature output everywhere
// RULE_03: minimum-code limit disables channel overtemperature
// RULE_04: ceiling bit picks full or programmed speed
// RULE_05: bypass bits remove voltage channel attenuators
// RULE_06: lock makes configuration register read-only
// RULE_07: configuration register resets to zero
// RULE_08: two read-only test registers read zero
// RULE_09: signed bit selects twos complement limits
// RULE_10: writes to test registers change nothing
module pin_cfg_regs
	import pin_cfg_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire reg_req_s req,
	input wire logic [2:0] ot_limit_hit,
	input wire logic [23:0] ot_limits,
	input wire logic [23:0] fan_max_speed,
	output logic [7:0] rdata,
	output pin_role_e shared_pin_role_select,
	output logic [3:0] bypass_divider_bits,
	output logic [3:0] fan_speed_is_bypass_scale,
	output logic overtemp_pin,
	output logic [23:0] fan_speed_cmd
);
	pin_cfg_s cfg_q;
	logic [7:0] ctrl_q;
	logic [7:0] test_one_q;
	logic [7:0] test_two_q;
	logic [2:0] ch_live;
	logic ot_any;
	logic cfg_wr;
	logic ctrl_wr;

	function automatic logic limit_off(input logic [7:0] lim, input logic signed_fmt);
		limit_off = signed_fmt ? (lim == LIMIT_OFF_TWOS) : (lim == LIMIT_OFF_OFS64);
	endfunction : limit_off

	function automatic logic write_to(input reg_req_s r, input logic [7:0] ofs);
		write_to = r.wr && r.addr == ofs;
	endfunction : write_to

	// write decode, lock gates config writes
	always_comb begin
		ctrl_wr = write_to(req, OFS_CTRL);
		cfg_wr = write_to(req, OFS_PIN_CFG) && !ctrl_q[CTRL_LOCK_BIT]; // RULE_06
	end

	// control: signed format and lock
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q <= RST_CTRL;
		end else if (ctrl_wr) begin
			ctrl_q <= {6'h00, req.wdata[CTRL_LOCK_BIT] | ctrl_q[CTRL_LOCK_BIT], req.wdata[CTRL_SIGNED_BIT]};
		end
	end

	lock_sticky_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_06
		ctrl_q[CTRL_LOCK_BIT]
		|=> ctrl_q[CTRL_LOCK_BIT])
		else $error("config lock dropped");
	signed_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_09
		(req.wr && req.addr == OFS_CTRL && req.wdata[CTRL_SIGNED_BIT])
		|=> ctrl_q[CTRL_SIGNED_BIT])
		else $error("signed format not taken");
	reset_lock_a: assert property (@(posedge clk_sys) // RULE_06
		!reset_n
		|=> ctrl_q == RST_CTRL)
		else $error("control not reset");

	// configuration register
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			cfg_q <= pin_cfg_s'(RST_PIN_CFG); // RULE_07
		end else if (cfg_wr) begin // RULE_06
			cfg_q <= pin_cfg_s'(req.wdata);
		end
	end

	lock_blocks_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_06
		(ctrl_q[CTRL_LOCK_BIT] && req.wr && req.addr == OFS_PIN_CFG)
		|=> $stable(cfg_q))
		else $error("locked config changed");
	cfg_write_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_06
		(!ctrl_q[CTRL_LOCK_BIT] && req.wr && req.addr == OFS_PIN_CFG)
		|=> cfg_q == pin_cfg_s'($past(req.wdata)))
		else $error("config write lost");
	reset_cfg_a: assert property (@(posedge clk_sys) // RULE_07
		!reset_n
		|=> cfg_q == pin_cfg_s'(8'h00))
		else $error("config not reset");

	// test registers hold their values whatever is written
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			test_one_q <= RST_TEST; // RULE_08
			test_two_q <= RST_TEST; // RULE_08
		end else begin
			test_one_q <= test_one_q; // RULE_10
			test_two_q <= test_two_q; // RULE_10
		end
	end

	// read port
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rdata <= 8'h00;
		end else if (req.rd) begin
			unique case (req.addr)
				OFS_PIN_CFG: rdata <= 8'(cfg_q);
				OFS_TEST_ONE: rdata <= test_one_q; // RULE_08
				OFS_TEST_TWO: rdata <= test_two_q; // RULE_08
				OFS_CTRL: rdata <= ctrl_q;
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	test_reads_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_08 RULE_10
		(req.rd && (req.addr == OFS_TEST_ONE || req.addr == OFS_TEST_TWO))
		|=> rdata == 8'h00)
		else $error("test register not zero");
	read_cfg_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_01
		(req.rd && req.addr == OFS_PIN_CFG)
		|=> rdata == 8'($past(cfg_q)))
		else $error("config read wrong");
	read_ctrl_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_09
		(req.rd && req.addr == OFS_CTRL)
		|=> rdata == $past(ctrl_q))
		else $error("control read wrong");
	unmapped_zero_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(req.rd && req.addr != OFS_PIN_CFG && req.addr != OFS_TEST_ONE
			&& req.addr != OFS_TEST_TWO && req.addr != OFS_CTRL)
		|=> rdata == 8'h00)
		else $error("unmapped read not zero");
	idle_rdata_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!req.rd
		|=> rdata == 8'h00)
		else $error("read data without read");

	// per-channel overtemperature qualification
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			ch_live[i] = ot_limit_hit[i] && !limit_off(ot_limits[i*8 +: 8], ctrl_q[CTRL_SIGNED_BIT]); // RULE_03 RULE_09
		end
		ot_any = |ch_live;
	end

	// pin role and overtemperature output
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			shared_pin_role_select <= ROLE_FAN_TACH;
			overtemp_pin <= 1'b0;
		end else begin
			shared_pin_role_select <= cfg_q.role; // RULE_01
			overtemp_pin <= ot_any && !cfg_q.ot_off && cfg_q.role == ROLE_OVERTEMP; // RULE_02
		end
	end

	role_follows_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_01
		1'b1
		|=> shared_pin_role_select == $past(cfg_q.role))
		else $error("pin role wrong");
	role_gate_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_01
		cfg_q.role != ROLE_OVERTEMP
		|=> !overtemp_pin)
		else $error("overtemp output in wrong role");
	ot_off_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_02
		cfg_q.ot_off
		|=> !overtemp_pin)
		else $error("overtemp output not suppressed");
	limit_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_03 RULE_09
		((!ot_limit_hit[0] || limit_off(ot_limits[7:0], ctrl_q[CTRL_SIGNED_BIT]))
			&& (!ot_limit_hit[1] || limit_off(ot_limits[15:8], ctrl_q[CTRL_SIGNED_BIT]))
			&& (!ot_limit_hit[2] || limit_off(ot_limits[23:16], ctrl_q[CTRL_SIGNED_BIT])))
		|=> !overtemp_pin && fan_speed_cmd == 24'h000000)
		else $error("disabled limit fired");
	ot_fires_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_02 RULE_03 RULE_09
		(ot_limit_hit[1] && ot_limits[15:8] != (ctrl_q[CTRL_SIGNED_BIT] ? LIMIT_OFF_TWOS : LIMIT_OFF_OFS64)
			&& !cfg_q.ot_off && cfg_q.role == ROLE_OVERTEMP)
		|=> overtemp_pin)
		else $error("live limit did not fire");

	// fan ceiling on overtemperature
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			fan_speed_cmd <= 24'h000000;
		end else if (ot_any && !cfg_q.ot_off) begin
			fan_speed_cmd <= cfg_q.ceiling_sel ? fan_max_speed : {3{FULL_SPEED}}; // RULE_04
		end else begin
			fan_speed_cmd <= 24'h000000;
		end
	end

	full_speed_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_04
		(ot_any && !cfg_q.ot_off && !cfg_q.ceiling_sel)
		|=> fan_speed_cmd == 24'hFFFFFF)
		else $error("fans not at full speed");
	max_speed_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_04
		(ot_any && !cfg_q.ot_off && cfg_q.ceiling_sel)
		|=> fan_speed_cmd == $past(fan_max_speed))
		else $error("fans not at max speed");
	fan_quiet_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_04
		cfg_q.ot_off
		|=> fan_speed_cmd == 24'h000000)
		else $error("fans driven while disabled");

	// attenuator bypass
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			bypass_divider_bits <= 4'h0;
			fan_speed_is_bypass_scale <= 4'h0;
		end else begin
			bypass_divider_bits <= cfg_q.bypass; // RULE_05
			fan_speed_is_bypass_scale <= cfg_q.bypass; // RULE_05
		end
	end

	bypass_out_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_05
		1'b1
		|=> bypass_divider_bits == $past(cfg_q.bypass))
		else $error("bypass bits wrong");
	bypass_scale_a: assert property (@(posedge clk_sys) disable iff (!reset_n) // RULE_05
		1'b1
		|=> fan_speed_is_bypass_scale == $past(cfg_q.bypass))
		else $error("bypass scale bits wrong");
	reset_outputs_a: assert property (@(posedge clk_sys) // RULE_07
		!reset_n
		|=> rdata == 8'h00 && shared_pin_role_select == ROLE_FAN_TACH && !overtemp_pin
			&& fan_speed_cmd == 24'h000000 && bypass_divider_bits == 4'h0 && fan_speed_is_bypass_scale == 4'h0)
		else $error("outputs not reset");
endmodule : pin_cfg_regs

// ===== verif/tb_pin_cfg_regs.sv
// self-checking bench for the pin and overtemperature configuration block
`timescale 1ns/1ps
module tb_pin_cfg_regs;
	import pin_cfg_pkg::*;
	logic clk_sys = 0;
	logic reset_n = 0;
	reg_req_s req = '0;
	logic [2:0] hit = '0;
	logic [23:0] lim = 24'h505050;
	logic [23:0] fmax = '0;
	logic [7:0] rdata, v;
	pin_role_e role;
	logic [3:0] byp, bsc;
	logic otp;
	logic [23:0] fcmd;
	logic [7:0] exp_q[$];
	logic rd_q = 0;
	int err_total = 0;
	int checks_done = 0;
	always #5 clk_sys = ~clk_sys;
	pin_cfg_regs dut(.clk_sys(clk_sys), .reset_n(reset_n), .req(req), .ot_limit_hit(hit), .ot_limits(lim),
		.fan_max_speed(fmax), .rdata(rdata), .shared_pin_role_select(role), .bypass_divider_bits(byp),
		.fan_speed_is_bypass_scale(bsc), .overtemp_pin(otp), .fan_speed_cmd(fcmd));
	task automatic chk(string n, logic [23:0] s, logic [23:0] e);
		checks_done++;
		if (s !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk_sys);
		req <= '0;
	endtask : wr
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge clk_sys);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		exp_q.push_back(e);
		@(posedge clk_sys);
		req <= '0;
	endtask : rd
	task automatic settle;
		repeat (3) @(posedge clk_sys);
	endtask : settle
	// read data compared one cycle after each read strobe
	always @(posedge clk_sys) begin
		rd_q <= req.rd;
		if (rd_q) chk("rdata", rdata, exp_q.pop_front());
	end
	initial begin
		void'($urandom(32'hC38D));
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		fmax <= 24'($urandom());
		rd(OFS_PIN_CFG, RST_PIN_CFG);
		rd(OFS_TEST_ONE, RST_TEST);
		wr(OFS_TEST_TWO, 8'hA5);
		rd(OFS_TEST_TWO, RST_TEST);
		rd(8'h10, 8'h00);
		$display("reset values done");
		for (int i = 0; i < 4; i++) begin
			v = {4'($urandom()), 2'b00, 2'(i)};
			wr(OFS_PIN_CFG, v);
			rd(OFS_PIN_CFG, v);
			settle();
			chk("role", 24'(role), 24'(i));
			chk("bypass", 24'(byp), 24'(v[7:4]));
			chk("bypass scale", 24'(bsc), 24'(v[7:4]));
		end
		$display("role and bypass done");
		hit <= 3'b010;
		for (int i = 0; i < 4; i++) begin
			wr(OFS_PIN_CFG, {4'h0, 2'(i), 2'b01});
			settle();
			chk("overtemp", 24'(otp), 24'(!i[0]));
			chk("fan cmd", fcmd, i[0] ? 24'h0 : (i[1] ? fmax : {3{FULL_SPEED}}));
		end
		$display("overtemp modes done");
		wr(OFS_PIN_CFG, 8'h01);
		lim[15:8] <= LIMIT_OFF_OFS64;
		settle();
		chk("ofs64 off", 24'(otp), 24'h0);
		wr(OFS_CTRL, 8'h01);
		settle();
		chk("twos active", 24'(otp), 24'h1);
		lim[15:8] <= LIMIT_OFF_TWOS;
		settle();
		chk("twos off", 24'(otp), 24'h0);
		$display("limit encoding done");
		wr(OFS_CTRL, 8'h03);
		wr(OFS_PIN_CFG, 8'hFE);
		rd(OFS_PIN_CFG, 8'h01);
		rd(OFS_CTRL, 8'h03);
		settle();
		chk("locked role", 24'(role), 24'(ROLE_OVERTEMP));
		$display("lock done");
		reset_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'b1;
		rd(OFS_PIN_CFG, RST_PIN_CFG);
		rd(OFS_CTRL, RST_CTRL);
		wr(OFS_PIN_CFG, 8'h02);
		rd(OFS_PIN_CFG, 8'h02);
		settle();
		chk("role after reset", 24'(role), 24'(ROLE_ALERT));
		chk("overtemp in alert role", 24'(otp), 24'h0);
		chk("fan after reset", fcmd, {3{FULL_SPEED}});
		$display("mid-run reset done");
		print_verdict();
	end
endmodule : tb_pin_cfg_regs
